/* inc/fsq_pkg.sv */
// Constants, field layout and the output carrier of the frame sequencer register bank.
// Assumes a 32-bit AXI4-Lite master and a frame start pulse from the sequencer core.
// Behaviour
// - Stats window bit selects configured-window subsampling
// - Three-bit probe select drives monitor pins
// - Line extension field lengthens rolling readout lines
// - Readout start delay applies only when enabled
// - Dual and triple slope only in global
// - Period meaning bit: reset length or frame length
// - Period field global only, timebase units
// - Dark row count 1 to 255, never zero
// - First row blank bit blanks first line
// - Filler row count used in rolling only
// - Timebase divider global only, clock units
// - Main exposure: lines rolling, timebase units global
// - Knee exposures global only, timebase units
// - Gain delay bit postpones gain one frame when sync bit 4 is set
// - Sync bit 0 holds line extension updates
// - Sync bit 1 holds dark row updates
// - Sync bit 2 holds filler row updates
// - Sync bit 3 holds exposure updates
// - Sync bit 4 holds gain updates
// - Main control bit 1 selects rolling shutter
// - Main control bit 6 enables readout delay
package fsq_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_MAIN = 6'h00;
  localparam logic [5:0] IDX_LINE = 6'h01;
  localparam logic [5:0] IDX_SLOPE = 6'h02;
  localparam logic [5:0] IDX_WIN = 6'h03;
  localparam logic [5:0] IDX_UNUSED = 6'h04;
  localparam logic [5:0] IDX_DARK = 6'h05;
  localparam logic [5:0] IDX_FILLER = 6'h06;
  localparam logic [5:0] IDX_TB = 6'h07;
  localparam logic [5:0] IDX_PERIOD = 6'h08;
  localparam logic [5:0] IDX_EXP = 6'h09;
  localparam logic [5:0] IDX_KNEE2 = 6'h0a;
  localparam logic [5:0] IDX_KNEE3 = 6'h0b;
  localparam logic [5:0] IDX_AGAIN = 6'h0c;
  localparam logic [5:0] IDX_DGAIN = 6'h0d;
  localparam logic [5:0] IDX_SYNC = 6'h0e;
  localparam logic [5:0] IDX_STATUS = 6'h0f;
  // Values after reset
  localparam logic [15:0] RST_MAIN = 16'h0000;
  localparam logic [15:0] RST_LINE = 16'h0000;
  localparam logic [15:0] RST_SLOPE = 16'h0004;
  localparam logic [15:0] RST_WIN = 16'h0001;
  localparam logic [15:0] RST_DARK = 16'h0102;
  localparam logic [15:0] RST_FILLER = 16'h0000;
  localparam logic [15:0] RST_TB = 16'h0001;
  localparam logic [15:0] RST_PERIOD = 16'h0000;
  localparam logic [15:0] RST_EXP = 16'h0000;
  localparam logic [15:0] RST_KNEE = 16'h0000;
  localparam logic [15:0] RST_AGAIN = 16'h01e2;
  localparam logic [15:0] RST_DGAIN = 16'h0080;
  localparam logic [15:0] RST_SYNC = 16'h033f;
  // Implemented bits; reserved bits read zero
  localparam logic [15:0] MSK_MAIN = 16'h3ff3;
  localparam logic [15:0] MSK_SLOPE = 16'h0007;
  localparam logic [15:0] MSK_WIN = 16'h00ff;
  localparam logic [15:0] MSK_DARK = 16'h01ff;
  localparam logic [15:0] MSK_FILLER = 16'h0fff;
  localparam logic [15:0] MSK_FULL = 16'hffff;
  localparam logic [15:0] MSK_AGAIN = 16'h21e3;
  localparam logic [15:0] MSK_DGAIN = 16'h0fff;
  localparam logic [15:0] MSK_SYNC = 16'h073f;
  // Field positions
  localparam int B_ROLLING = 1;
  localparam int B_DLY_EN = 6;
  localparam int B_STATS_WIN = 10;
  localparam int B_PROBE_LO = 11;
  localparam int B_DUAL = 0;
  localparam int B_TRIPLE = 1;
  localparam int B_PERIOD_SEL = 2;
  localparam int B_BLANK = 8;
  localparam int B_GAIN_DLY = 13;
  localparam int S_LINE = 0;
  localparam int S_DARK = 1;
  localparam int S_FILLER = 2;
  localparam int S_EXP = 3;
  localparam int S_GAIN = 4;
  localparam logic [7:0] DARK_MIN = 8'h01;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Active configuration seen by the sequencer core
  typedef struct packed {
    logic rolling_mode;
    logic stats_window_only;
    logic [2:0] probe_select;
    logic [7:0] rolling_line_extension;
    logic [7:0] readout_start_delay;
    logic dual_slope;
    logic triple_slope;
    logic period_meaning_select;
    logic [15:0] frame_or_reset_period;
    logic [15:0] timebase_divider;
    logic [7:0] dark_row_count;
    logic first_row_blank;
    logic [11:0] filler_row_count;
    logic [15:0] main_exposure_time;
    logic [15:0] second_knee_exposure;
    logic [15:0] third_knee_exposure;
    logic [15:0] analog_gain;
    logic [11:0] digital_gain;
    logic [7:0] window_select;
  } fsq_cfg_s;
endpackage

/* src/fsq_regs.sv */
// Frame sequencer configuration bank: AXI4-Lite slave, shadow and active copies.
// Assumes frame_start is a one-cycle pulse in the aclk domain from the sequencer core.
//
// Implementation choice: the AXI4-Lite interface to the registers.
module fsq_regs #(
  parameter int ADDR_W = 8 // Byte address width
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_start,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output fsq_pkg::fsq_cfg_s cfg
);

  // Software copies of each register
  logic [15:0] main_q;
  logic [15:0] line_q;
  logic [15:0] slope_q;
  logic [15:0] win_q;
  logic [15:0] dark_q;
  logic [15:0] filler_q;
  logic [15:0] tb_q;
  logic [15:0] period_q;
  logic [15:0] exp_q;
  logic [15:0] knee2_q;
  logic [15:0] knee3_q;
  logic [15:0] again_q;
  logic [15:0] dgain_q;
  logic [15:0] sync_q;
  // Active copies of frame-synchronised fields
  logic [7:0] act_line_q;
  logic [8:0] act_dark_q;
  logic [11:0] act_filler_q;
  logic [15:0] act_exp_q;
  logic [15:0] act_knee2_q;
  logic [15:0] act_knee3_q;
  logic [15:0] stage_again_q; // Gain waiting one frame
  logic [11:0] stage_dgain_q;
  logic [15:0] act_again_q;
  logic [11:0] act_dgain_q;
  logic [4:0] pend_q; // Shadow written, not yet active
  logic [4:0] pend_set;
  logic [4:0] pend_clr;
  // Bus side state
  logic aw_hold_q;
  logic w_hold_q;
  logic [5:0] aw_idx_q;
  logic [15:0] wdata_q;
  logic [1:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  fsq_pkg::fsq_cfg_s cfg_q;
  logic do_write;
  logic [15:0] rd_word;
  logic rd_ok;
  logic wr_ok;
  logic [5:0] ar_idx;

  // Byte-lane merge of a write into a register copy
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] strb, input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = nw[7:0];
    end
    if (strb[1]) begin
      r[15:8] = nw[15:8];
    end
    return r & msk;
  endfunction

  assign ar_idx = araddr[7:2];
  // Write fires once both address and data are held and no response waits
  assign do_write = aw_hold_q & w_hold_q & ~bvalid_q;

  // Writable index check; the unused word accepts and discards data
  always_comb begin
    wr_ok = (aw_idx_q <= fsq_pkg::IDX_SYNC);
  end

  // Write address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_idx_q <= 6'h00;
      awready_q <= 1'b1;
    end else if (awvalid && awready_q) begin
      aw_hold_q <= 1'b1;
      aw_idx_q <= awaddr[7:2];
      awready_q <= 1'b0;
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
      awready_q <= 1'b1;
    end
  end

  // Write data capture; only the low 16 bits are stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 16'h0000;
      wstrb_q <= 2'h0;
      wready_q <= 1'b1;
    end else if (wvalid && wready_q) begin
      w_hold_q <= 1'b1;
      wdata_q <= wdata[15:0];
      wstrb_q <= wstrb[1:0];
      wready_q <= 1'b0;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
      wready_q <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= fsq_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Register file writes into the software copies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_q <= fsq_pkg::RST_MAIN;
      line_q <= fsq_pkg::RST_LINE;
      slope_q <= fsq_pkg::RST_SLOPE;
      win_q <= fsq_pkg::RST_WIN;
      dark_q <= fsq_pkg::RST_DARK;
      filler_q <= fsq_pkg::RST_FILLER;
      tb_q <= fsq_pkg::RST_TB;
      period_q <= fsq_pkg::RST_PERIOD;
      exp_q <= fsq_pkg::RST_EXP;
      knee2_q <= fsq_pkg::RST_KNEE;
      knee3_q <= fsq_pkg::RST_KNEE;
      again_q <= fsq_pkg::RST_AGAIN;
      dgain_q <= fsq_pkg::RST_DGAIN;
      sync_q <= fsq_pkg::RST_SYNC;
    end else if (do_write) begin
      if (aw_idx_q == fsq_pkg::IDX_MAIN) begin
        main_q <= merge(main_q, wdata_q, wstrb_q, fsq_pkg::MSK_MAIN);
      end else if (aw_idx_q == fsq_pkg::IDX_LINE) begin
        line_q <= merge(line_q, wdata_q, wstrb_q, fsq_pkg::MSK_FULL);
      end else if (aw_idx_q == fsq_pkg::IDX_SLOPE) begin
        slope_q <= merge(slope_q, wdata_q, wstrb_q, fsq_pkg::MSK_SLOPE);
      end else if (aw_idx_q == fsq_pkg::IDX_WIN) begin
        win_q <= merge(win_q, wdata_q, wstrb_q, fsq_pkg::MSK_WIN);
      end else if (aw_idx_q == fsq_pkg::IDX_DARK) begin
        dark_q <= merge(dark_q, wdata_q, wstrb_q, fsq_pkg::MSK_DARK);
      end else if (aw_idx_q == fsq_pkg::IDX_FILLER) begin
        filler_q <= merge(filler_q, wdata_q, wstrb_q, fsq_pkg::MSK_FILLER);
      end else if (aw_idx_q == fsq_pkg::IDX_TB) begin
        tb_q <= merge(tb_q, wdata_q, wstrb_q, fsq_pkg::MSK_FULL);
      end else if (aw_idx_q == fsq_pkg::IDX_PERIOD) begin
        period_q <= merge(period_q, wdata_q, wstrb_q, fsq_pkg::MSK_FULL);
      end else if (aw_idx_q == fsq_pkg::IDX_EXP) begin
        exp_q <= merge(exp_q, wdata_q, wstrb_q, fsq_pkg::MSK_FULL);
      end else if (aw_idx_q == fsq_pkg::IDX_KNEE2) begin
        knee2_q <= merge(knee2_q, wdata_q, wstrb_q, fsq_pkg::MSK_FULL);
      end else if (aw_idx_q == fsq_pkg::IDX_KNEE3) begin
        knee3_q <= merge(knee3_q, wdata_q, wstrb_q, fsq_pkg::MSK_FULL);
      end else if (aw_idx_q == fsq_pkg::IDX_AGAIN) begin
        again_q <= merge(again_q, wdata_q, wstrb_q, fsq_pkg::MSK_AGAIN);
      end else if (aw_idx_q == fsq_pkg::IDX_DGAIN) begin
        dgain_q <= merge(dgain_q, wdata_q, wstrb_q, fsq_pkg::MSK_DGAIN);
      end else if (aw_idx_q == fsq_pkg::IDX_SYNC) begin
        sync_q <= merge(sync_q, wdata_q, wstrb_q, fsq_pkg::MSK_SYNC);
      end
    end
  end

  // Pending flags: a synced write sets, a load clears, set wins
  always_comb begin
    pend_set = 5'h00;
    pend_clr = 5'h00;
    if (do_write) begin
      pend_set[fsq_pkg::S_LINE] = (aw_idx_q == fsq_pkg::IDX_LINE);
      pend_set[fsq_pkg::S_DARK] = (aw_idx_q == fsq_pkg::IDX_DARK);
      pend_set[fsq_pkg::S_FILLER] = (aw_idx_q == fsq_pkg::IDX_FILLER);
      pend_set[fsq_pkg::S_EXP] = (aw_idx_q >= fsq_pkg::IDX_EXP) &&
                                 (aw_idx_q <= fsq_pkg::IDX_KNEE3);
      pend_set[fsq_pkg::S_GAIN] = (aw_idx_q == fsq_pkg::IDX_AGAIN) ||
                                  (aw_idx_q == fsq_pkg::IDX_DGAIN);
    end
    pend_set = pend_set & sync_q[4:0];
    // Unsynced groups never wait for a frame start
    pend_clr = ~sync_q[4:0] | {5{frame_start}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= 5'h00;
    end else begin
      pend_q <= pend_set | (pend_q & ~pend_clr);
    end
  end

  // Line extension: shadow to active at frame start or at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_line_q <= fsq_pkg::RST_LINE[7:0];
    end else if (!sync_q[fsq_pkg::S_LINE] || frame_start) begin
      act_line_q <= line_q[7:0];
    end
  end

  // Dark rows and first row blank
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_dark_q <= fsq_pkg::RST_DARK[8:0];
    end else if (!sync_q[fsq_pkg::S_DARK] || frame_start) begin
      act_dark_q <= dark_q[8:0];
    end
  end

  // Filler rows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_filler_q <= fsq_pkg::RST_FILLER[11:0];
    end else if (!sync_q[fsq_pkg::S_FILLER] || frame_start) begin
      act_filler_q <= filler_q[11:0];
    end
  end

  // Exposure group: main and both knee times move together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_exp_q <= fsq_pkg::RST_EXP;
      act_knee2_q <= fsq_pkg::RST_KNEE;
      act_knee3_q <= fsq_pkg::RST_KNEE;
    end else if (!sync_q[fsq_pkg::S_EXP] || frame_start) begin
      act_exp_q <= exp_q;
      act_knee2_q <= knee2_q;
      act_knee3_q <= knee3_q;
    end
  end

  // Gain group; the delay bit adds one frame stage to track exposure latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_again_q <= fsq_pkg::RST_AGAIN;
      stage_dgain_q <= fsq_pkg::RST_DGAIN[11:0];
      act_again_q <= fsq_pkg::RST_AGAIN;
      act_dgain_q <= fsq_pkg::RST_DGAIN[11:0];
    end else if (!sync_q[fsq_pkg::S_GAIN]) begin
      stage_again_q <= again_q;
      stage_dgain_q <= dgain_q[11:0];
      act_again_q <= again_q;
      act_dgain_q <= dgain_q[11:0];
    end else if (frame_start) begin
      stage_again_q <= again_q;
      stage_dgain_q <= dgain_q[11:0];
      if (again_q[fsq_pkg::B_GAIN_DLY]) begin
        act_again_q <= stage_again_q;
        act_dgain_q <= stage_dgain_q;
      end else begin
        act_again_q <= again_q;
        act_dgain_q <= dgain_q[11:0];
      end
    end
  end

  // Active configuration, gated by shutter mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= '0;
    end else begin
      cfg_q.rolling_mode <= main_q[fsq_pkg::B_ROLLING];
      cfg_q.stats_window_only <= main_q[fsq_pkg::B_STATS_WIN];
      cfg_q.probe_select <= main_q[fsq_pkg::B_PROBE_LO +: 3];
      // Line extension only lengthens rolling readout
      cfg_q.rolling_line_extension <= main_q[fsq_pkg::B_ROLLING] ? act_line_q : 8'h00;
      // Delay is zero unless its enable is set
      cfg_q.readout_start_delay <= main_q[fsq_pkg::B_DLY_EN] ? line_q[15:8] : 8'h00;
      cfg_q.dual_slope <= slope_q[fsq_pkg::B_DUAL] & ~main_q[fsq_pkg::B_ROLLING];
      cfg_q.triple_slope <= slope_q[fsq_pkg::B_TRIPLE] & ~main_q[fsq_pkg::B_ROLLING];
      cfg_q.period_meaning_select <= slope_q[fsq_pkg::B_PERIOD_SEL];
      // Period and timebase mean nothing in rolling mode
      cfg_q.frame_or_reset_period <= main_q[fsq_pkg::B_ROLLING] ? 16'h0000 : period_q;
      cfg_q.timebase_divider <= main_q[fsq_pkg::B_ROLLING] ? 16'h0000 : tb_q;
      // A zero count would stall the sequencer, so it is clamped
      cfg_q.dark_row_count <= (act_dark_q[7:0] == 8'h00) ?
                              fsq_pkg::DARK_MIN : act_dark_q[7:0];
      cfg_q.first_row_blank <= act_dark_q[fsq_pkg::B_BLANK];
      cfg_q.filler_row_count <= main_q[fsq_pkg::B_ROLLING] ? act_filler_q : 12'h000;
      // Unit is lines in rolling, timebase ticks in global
      cfg_q.main_exposure_time <= act_exp_q;
      cfg_q.second_knee_exposure <= main_q[fsq_pkg::B_ROLLING] ? 16'h0000 : act_knee2_q;
      cfg_q.third_knee_exposure <= main_q[fsq_pkg::B_ROLLING] ? 16'h0000 : act_knee3_q;
      cfg_q.analog_gain <= act_again_q;
      cfg_q.digital_gain <= act_dgain_q;
      cfg_q.window_select <= win_q[7:0];
    end
  end

  // Read mux; unmapped indices answer SLVERR with zero data
  always_comb begin
    rd_word = 16'h0000;
    rd_ok = 1'b1;
    if (ar_idx == fsq_pkg::IDX_MAIN) begin
      rd_word = main_q;
    end else if (ar_idx == fsq_pkg::IDX_LINE) begin
      rd_word = line_q;
    end else if (ar_idx == fsq_pkg::IDX_SLOPE) begin
      rd_word = slope_q;
    end else if (ar_idx == fsq_pkg::IDX_WIN) begin
      rd_word = win_q;
    end else if (ar_idx == fsq_pkg::IDX_UNUSED) begin
      rd_word = 16'h0000;
    end else if (ar_idx == fsq_pkg::IDX_DARK) begin
      rd_word = dark_q;
    end else if (ar_idx == fsq_pkg::IDX_FILLER) begin
      rd_word = filler_q;
    end else if (ar_idx == fsq_pkg::IDX_TB) begin
      rd_word = tb_q;
    end else if (ar_idx == fsq_pkg::IDX_PERIOD) begin
      rd_word = period_q;
    end else if (ar_idx == fsq_pkg::IDX_EXP) begin
      rd_word = exp_q;
    end else if (ar_idx == fsq_pkg::IDX_KNEE2) begin
      rd_word = knee2_q;
    end else if (ar_idx == fsq_pkg::IDX_KNEE3) begin
      rd_word = knee3_q;
    end else if (ar_idx == fsq_pkg::IDX_AGAIN) begin
      rd_word = again_q;
    end else if (ar_idx == fsq_pkg::IDX_DGAIN) begin
      rd_word = dgain_q;
    end else if (ar_idx == fsq_pkg::IDX_SYNC) begin
      rd_word = sync_q;
    end else if (ar_idx == fsq_pkg::IDX_STATUS) begin
      // Live state: active line extension and pending groups
      rd_word = {act_line_q, 3'h0, pend_q};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read channel, one read at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= fsq_pkg::RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {16'h0000, rd_word};
      rresp_q <= rd_ok ? fsq_pkg::RESP_OKAY : fsq_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign cfg = cfg_q;

endmodule // fsq_regs

/* verification/fsq_regs_properties.sv */
// Checker for the frame sequencer register bank.
// Assumes it is bound to fsq_regs and sees only its ports.
module fsq_regs_properties #(
  parameter int ADDR_W = 8 // Byte address width
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_start,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input fsq_pkg::fsq_cfg_s cfg
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write halves taken with no answer pending
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready && !bvalid;
  endsequence
  // Answer within two edges
  sequence s_wr_answer;
    ##[1:2] bvalid;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> s_wr_answer)
    else $error("write response late");
  a_read_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data not held");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_read_upper: assert property (rvalid |-> rdata[31:16] == 16'h0000 && !arready)
    else $error("read upper half or arready wrong");
  // Skip the first edges after release, cfg still loading
  a_dark_floor: assert property ($past(aresetn, 2) |-> cfg.dark_row_count != 8'h00)
    else $error("dark row count zero");
  a_rolling_gate: assert property (cfg.rolling_mode |->
    {cfg.frame_or_reset_period, cfg.timebase_divider, cfg.second_knee_exposure,
     cfg.third_knee_exposure, cfg.dual_slope, cfg.triple_slope} == '0)
    else $error("global field active in rolling");
  a_global_gate: assert property (!cfg.rolling_mode |->
    cfg.rolling_line_extension == 8'h00 && cfg.filler_row_count == 12'h000)
    else $error("rolling field active in global");
endmodule // fsq_regs_properties

bind fsq_regs fsq_regs_properties #(.ADDR_W(ADDR_W)) fsq_regs_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .frame_start(frame_start), .awaddr(awaddr),
  .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .cfg(cfg));

/* verification/fsq_regs_test.sv */
// Self-checking bench for the frame sequencer register bank.
// Assumes the checker file is compiled alongside; drives AXI4-Lite itself.
module fsq_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, frame_start;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  fsq_pkg::fsq_cfg_s cfg;
  int errors, total_checks, cycles;
  // Reset values and writable masks, indices 0 to 14
  logic [15:0] rst_tab [15] = '{16'h0000, 16'h0000, 16'h0004, 16'h0001, 16'h0000,
    16'h0102, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01e2,
    16'h0080, 16'h033f};
  logic [15:0] msk_tab [15] = '{16'h3ff3, 16'hffff, 16'h0007, 16'h00ff, 16'h0000,
    16'h01ff, 16'h0fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h21e3,
    16'h0fff, 16'h073f};
  // Sync groups: line, dark, filler, exposure, gain
  logic [5:0] grp_idx [5] = '{6'h01, 6'h05, 6'h06, 6'h09, 6'h0c};
  logic [15:0] grp_old [5] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h01e2};
  logic [15:0] grp_a [5] = '{16'h00a5, 16'h0107, 16'h0abc, 16'h4321, 16'h0003};
  logic [15:0] grp_b [5] = '{16'h005a, 16'h0109, 16'h0123, 16'h1111, 16'h0001};
  // Width of the active field each group drives
  logic [15:0] grp_msk [5] = '{16'h00ff, 16'h00ff, 16'h0fff, 16'hffff, 16'hffff};

  fsq_regs #(.ADDR_W(8)) fsq_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .frame_start(frame_start), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cfg(cfg));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Hang guard, well above the few hundred cycles needed
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Reset held two edges; three more edges pass before the first request
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask

  task automatic pulse;
    @(posedge aclk);
    frame_start <= 1'b1;
    @(posedge aclk);
    frame_start <= 1'b0;
    settle();
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {16'h0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        a = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    check_val("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    check_val("rdata", {16'h0000, exp}, rdata);
    check_val("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] fld(input int g);
    case (g)
      0: return {24'h0, cfg.rolling_line_extension};
      1: return {24'h0, cfg.dark_row_count};
      2: return {20'h0, cfg.filler_row_count};
      3: return {16'h0, cfg.main_exposure_time};
      default: return {16'h0, cfg.analog_gain};
    endcase
  endfunction

  // Reset values, read-back masks, reserved word and unmapped places
  task automatic t_regs;
    for (int i = 0; i < 15; i++) rd(i[5:0], rst_tab[i], 2'h0);
    for (int i = 0; i < 15; i++) begin
      wr(i[5:0], 16'hffff, 2'h0);
      rd(i[5:0], msk_tab[i], 2'h0);
    end
    wr(6'h20, 16'h1234, 2'h2);
    rd(6'h10, 16'h0000, 2'h2);
    do_reset();
  endtask

  // Held updates wait for frame start, free updates land at once
  task automatic t_sync;
    wr(6'h00, 16'h0002, 2'h0);
    for (int g = 0; g < 5; g++) begin
      wr(grp_idx[g], grp_a[g], 2'h0);
      settle();
      check_val("held", {16'h0, grp_old[g] & grp_msk[g]}, fld(g));
      rd(6'h0f, {(g == 0) ? 8'h00 : 8'ha5, 8'(1 << g)}, 2'h0);
      pulse();
      check_val("loaded", {16'h0, grp_a[g] & grp_msk[g]}, fld(g));
    end
    wr(6'h0e, 16'h0000, 2'h0);
    for (int g = 0; g < 5; g++) begin
      wr(grp_idx[g], grp_b[g], 2'h0);
      settle();
      check_val("free", {16'h0, grp_b[g] & grp_msk[g]}, fld(g));
    end
    do_reset();
  endtask

  // Delayed gain takes two frame starts
  task automatic t_gain_delay;
    wr(6'h0c, 16'h2003, 2'h0);
    pulse();
    check_val("gain first", 32'h01e2, {16'h0, cfg.analog_gain});
    pulse();
    check_val("gain second", 32'h2003, {16'h0, cfg.analog_gain});
    do_reset();
  endtask

  // Mode gating of global fields in both shutter modes, plus pass-through fields
  task automatic t_gating;
    wr(6'h0e, 16'h0000, 2'h0);
    wr(6'h01, 16'h5a00, 2'h0);
    wr(6'h02, 16'h0003, 2'h0);
    wr(6'h07, 16'h1234, 2'h0);
    wr(6'h08, 16'h0777, 2'h0);
    wr(6'h0a, 16'h0022, 2'h0);
    wr(6'h00, 16'h3c40, 2'h0);
    settle();
    check_val("global", {8'h5a, 1'b1, 3'h7, 1'b0, 1'b1, 1'b1, 1'b0},
      {cfg.readout_start_delay, cfg.stats_window_only, cfg.probe_select, cfg.rolling_mode,
       cfg.dual_slope, cfg.triple_slope, cfg.period_meaning_select});
    check_val("timing", {16'h1234, 16'h0777},
      {cfg.timebase_divider, cfg.frame_or_reset_period});
    check_val("knee", 32'h0022, {16'h0, cfg.second_knee_exposure});
    wr(6'h03, 16'h00c3, 2'h0);
    wr(6'h0b, 16'h0033, 2'h0);
    wr(6'h0d, 16'h0456, 2'h0);
    settle();
    check_val("misc", {8'hc3, 12'h456, 12'h033},
      {cfg.window_select, cfg.digital_gain, cfg.third_knee_exposure[11:0]});
    wr(6'h00, 16'h0002, 2'h0);
    wr(6'h05, 16'h0000, 2'h0);
    settle();
    check_val("rolling", {8'h00, 1'b1, 1'b0, 1'b0, 16'h0000},
      {cfg.readout_start_delay, cfg.rolling_mode, cfg.dual_slope, cfg.triple_slope,
       cfg.timebase_divider});
    check_val("dark", {8'h01, 1'b0}, {cfg.dark_row_count, cfg.first_row_blank});
  endtask

  // Main sequence
  initial begin
    {aresetn, frame_start, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    do_reset();
    check_val("cfg reset", {8'h02, 1'b1, 1'b1, 16'h0001},
      {cfg.dark_row_count, cfg.first_row_blank, cfg.period_meaning_select,
       cfg.timebase_divider});
    t_regs();
    t_sync();
    t_gain_delay();
    t_gating();
    results();
  end
endmodule // fsq_regs_test
